// ---- core/ctrc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - device stores 8192 words of 8 bits
// R2 - low 13 bits index, high 8 compared
// R3 - idle strobes compare; mismatch pulls hit low
// R4 - equal tag releases hit high
// R5 - hit is open-drain with pull-up
// R6 - hit lines wire-OR across devices
// R7 - two devices cascade for 29 bits; host drives one device with 21-bit addresses
// R8 - clear low zeroes every word
// R9 - clear releases hit, data undriven
// R10 - host clears at power-on and reset
// R11 - chip deselected: pins float, hit released
// R12 - read drives word, hit released
// R13 - write stores data, drivers off
// R14 - also usable as plain memory
// R15 - strobes inactive on address changes
// R16 - select after write enable: outputs float
// R17 - no floating inputs during compare
// R18 - device answers combinationally from levels
module ctrc_host
    import ctrc_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire ctrc_pkg::ctrc_op_e          req_op,
    input  wire logic [ctrc_pkg::FULL_W-1:0] req_addr,
    input  wire logic [ctrc_pkg::TAG_W-1:0]  req_wdata,
    output logic                             rsp_valid,
    output logic                             rsp_hit,
    output logic      [ctrc_pkg::TAG_W-1:0]  rsp_rdata,
    output logic      [ctrc_pkg::ADDR_W-1:0] index_addr,
    output logic                             chip_sel_n,
    output logic                             write_en_n,
    output logic                             out_en_n,
    output logic                             clear_n,
    input  wire logic [ctrc_pkg::TAG_W-1:0]  tag_data_in,
    output logic      [ctrc_pkg::TAG_W-1:0]  tag_data_out,
    output logic                             tag_data_oe_n,
    input  wire logic                        hit_n_in
);
    import ctrc_pkg::*;

    default clocking ctrc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ========================================
    // sequencer
    typedef enum logic [2:0] {
        CTRC_ST_INIT, CTRC_ST_IDLE, CTRC_ST_SETUP, CTRC_ST_STROBE,
        CTRC_ST_SAMPLE, CTRC_ST_DONE, CTRC_ST_CLEAR, CTRC_ST_RECOVER
    } ctrc_st_e;

    function automatic logic [ADDR_W-1:0] idx_of(input logic [FULL_W-1:0] a);
        return a[TAG_LSB-1:INDEX_LSB]; // R2
    endfunction : idx_of
    function automatic logic [TAG_W-1:0] tag_of(input logic [FULL_W-1:0] a);
        return a[FULL_W-1:TAG_LSB]; // R2
    endfunction : tag_of

    ctrc_st_e           st_reg;
    ctrc_op_e           op_reg;
    logic [3:0]         cnt_reg;
    logic [TAG_W-1:0]   wdat_reg;
    logic               drive_en;
    logic [TAG_W-1:0]   drive_val;
    logic [TAG_W-1:0]   rd_sample;
    logic               hit_sample;

    assign req_ready = (st_reg == CTRC_ST_IDLE);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg  <= CTRC_ST_INIT;
            cnt_reg <= CNT_ZERO;
        end else begin
            unique case (st_reg)
                CTRC_ST_INIT: begin
                    st_reg  <= CTRC_ST_CLEAR; // R10
                    cnt_reg <= CNT_CLEAR;
                end
                CTRC_ST_IDLE: begin
                    if (req_valid && req_op == CTRC_OP_CLEAR) begin
                        st_reg  <= CTRC_ST_CLEAR;
                        cnt_reg <= CNT_CLEAR;
                    end else if (req_valid) begin
                        st_reg <= CTRC_ST_SETUP;
                    end
                end
                CTRC_ST_SETUP:  st_reg <= CTRC_ST_STROBE;
                CTRC_ST_STROBE: st_reg <= CTRC_ST_SAMPLE;
                CTRC_ST_SAMPLE: st_reg <= CTRC_ST_DONE;
                CTRC_ST_DONE:   st_reg <= CTRC_ST_IDLE;
                CTRC_ST_CLEAR: begin
                    if (cnt_reg <= 4'h1) begin
                        st_reg  <= CTRC_ST_RECOVER;
                        cnt_reg <= CNT_REC;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                CTRC_ST_RECOVER: begin
                    if (cnt_reg <= 4'h1) begin
                        st_reg  <= CTRC_ST_IDLE;
                        cnt_reg <= CNT_ZERO;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
            endcase
        end
    end

    // clear follows every reset, strobes idle in recovery
    a_reset_clears: assert property ( // R10
        $rose(nrst) |-> ##1 !clear_n)
        else $error("no clear after reset");
    a_clear_recover: assert property ( // R8
        $rose(clear_n) |-> write_en_n && chip_sel_n && !req_ready)
        else $error("strobes active in clear recovery");

    // ========================================
    // request capture; address changes only while strobes idle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_reg     <= CTRC_OP_LOOKUP;
            index_addr <= IDX_ZERO;
            wdat_reg   <= TAG_ZERO;
        end else if (req_ready && req_valid && req_op != CTRC_OP_CLEAR) begin
            op_reg     <= req_op;
            index_addr <= idx_of(req_addr); // R15
            wdat_reg   <= (req_op == CTRC_OP_WRITE) ? req_wdata
                                                    : tag_of(req_addr);
        end
    end

    a_addr_strobe_idle: assert property ( // R15
        $changed(index_addr) |-> chip_sel_n && write_en_n)
        else $error("address changed under strobe");

    // ========================================
    // strobes: write enable falls on the same edge as select, output enable kept off for writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
            clear_n    <= 1'b1;
        end else begin
            clear_n    <= !(st_reg == CTRC_ST_INIT ||
                           (st_reg == CTRC_ST_CLEAR && cnt_reg > 4'h1)); // R8
            write_en_n <= !((st_reg == CTRC_ST_SETUP ||
                             st_reg == CTRC_ST_STROBE) &&
                            op_reg == CTRC_OP_WRITE); // R16
            chip_sel_n <= !(st_reg == CTRC_ST_SETUP ||
                            (st_reg == CTRC_ST_STROBE &&
                             op_reg != CTRC_OP_WRITE)); // R15
            out_en_n   <= !((st_reg == CTRC_ST_SETUP ||
                             st_reg == CTRC_ST_STROBE) &&
                            op_reg == CTRC_OP_READ); // R12
        end
    end

    a_we_leads_cs: assert property ( // R16
        $fell(write_en_n) |-> $past(chip_sel_n))
        else $error("select fell before write enable");
    a_clear_strobes_off: assert property ( // R10
        !clear_n |-> chip_sel_n && tag_data_oe_n)
        else $error("strobes active during clear");
    a_no_contention: assert property ( // R12
        !out_en_n |-> tag_data_oe_n)
        else $error("host drives data during read");

    // data pins driven for lookup and write, never in read or clear
    always_comb begin
        drive_en  = (st_reg == CTRC_ST_SETUP || st_reg == CTRC_ST_STROBE ||
                     st_reg == CTRC_ST_SAMPLE) &&
                    op_reg != CTRC_OP_READ; // R17
        drive_val = wdat_reg; // R2
    end

    ctrc_pin_drv u_pin (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .drive_en     (drive_en),
        .drive_val    (drive_val),
        .tag_data_in  (tag_data_in),
        .hit_in       (hit_n_in), // R7
        .tag_data_out (tag_data_out),
        .tag_data_oe_n(tag_data_oe_n),
        .rd_sample    (rd_sample),
        .hit_sample   (hit_sample)
    );

    a_lookup_drive: assert property ( // R17
        !chip_sel_n && write_en_n && out_en_n |-> !tag_data_oe_n)
        else $error("data floats during compare");

    // ========================================
    // answer: wired hit line high means every device matched
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_hit   <= 1'b0;
            rsp_rdata <= TAG_ZERO;
        end else begin
            rsp_valid <= (st_reg == CTRC_ST_DONE);
            if (st_reg == CTRC_ST_DONE) begin
                rsp_hit   <= (op_reg == CTRC_OP_LOOKUP) && hit_sample; // R6
                rsp_rdata <= rd_sample; // R14
            end
        end
    end

    // answer pulse five samples after the taking edge
    a_rsp_timing: assert property ( // R3
        req_valid && req_ready && req_op != CTRC_OP_CLEAR |-> ##5 rsp_valid)
        else $error("answer not on fifth cycle");
endmodule : ctrc_host
`default_nettype wire

// ---- core/ctrc_pkg.sv ----
package ctrc_pkg;
    // ========================================
    // geometry
    localparam int ADDR_W    = 13;
    localparam int TAG_W     = 8;
    localparam int FULL_W    = 21;
    localparam int DEPTH     = 8192;
    localparam int INDEX_LSB = 0;
    localparam int TAG_LSB   = 13;
    // ========================================
    // timing, ns and cycles at 100 ns
    localparam int CLK_NS        = 100;
    localparam int CLEAR_PW_NS   = 45;
    localparam int CLEAR_REC_NS  = 30;
    localparam int POR_NS        = 120;
    localparam int CLEAR_CYC     = (CLEAR_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLEAR_REC_CYC = (CLEAR_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_CYC       = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLR_HOLD_CYC  = POR_CYC > CLEAR_CYC ? POR_CYC : CLEAR_CYC;
    localparam logic [3:0] CNT_CLEAR = 4'(CLR_HOLD_CYC);
    localparam logic [3:0] CNT_REC   = 4'(CLEAR_REC_CYC);
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [7:0] TAG_ZERO  = 8'h00;
    localparam logic [12:0] IDX_ZERO = 13'h0000;

    typedef enum logic [1:0] {
        CTRC_OP_LOOKUP,
        CTRC_OP_READ,
        CTRC_OP_WRITE,
        CTRC_OP_CLEAR
    } ctrc_op_e;
endpackage : ctrc_pkg

// ---- core/ctrc_pin_drv.sv ----
`timescale 1ns/10ps
`default_nettype none
// ========================================
// pin driver: three-signal split of data, open-drain hit sampling
module ctrc_pin_drv
    import ctrc_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    input  wire logic                      drive_en,
    input  wire logic [ctrc_pkg::TAG_W-1:0] drive_val,
    input  wire logic [ctrc_pkg::TAG_W-1:0] tag_data_in,
    input  wire logic                      hit_in,
    output logic      [ctrc_pkg::TAG_W-1:0] tag_data_out,
    output logic                           tag_data_oe_n,
    output logic      [ctrc_pkg::TAG_W-1:0] rd_sample,
    output logic                           hit_sample
);
    import ctrc_pkg::*;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tag_data_out  <= TAG_ZERO;
            tag_data_oe_n <= 1'b1;
        end else begin
            tag_data_out  <= drive_val;
            tag_data_oe_n <= !drive_en;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_sample  <= TAG_ZERO;
            hit_sample <= 1'b0;
        end else begin
            rd_sample  <= tag_data_in;
            hit_sample <= hit_in;
        end
    end
endmodule : ctrc_pin_drv
`default_nettype wire

// ---- tb/ctrc_tag_ram_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ========================================
// tag ram model: answers from input levels only
module ctrc_tag_ram_model
    import ctrc_pkg::*;
(
    input  wire logic [ctrc_pkg::ADDR_W-1:0] index_addr,
    input  wire logic                        chip_sel_n,
    input  wire logic                        write_en_n,
    input  wire logic                        out_en_n,
    input  wire logic                        clear_n,
    input  wire logic [ctrc_pkg::TAG_W-1:0]  tag_data,
    output logic      [ctrc_pkg::TAG_W-1:0]  dev_data,
    output logic                             dev_drive,
    output logic                             hit_pull_low
);
    import ctrc_pkg::*;
    logic [TAG_W-1:0] mem_reg [DEPTH];
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] = 8'hA5;
        end
    end
    always @(clear_n or chip_sel_n or write_en_n or index_addr
             or tag_data) begin
        if (!clear_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] = TAG_ZERO;
            end
        end else if (!chip_sel_n && !write_en_n) begin
            mem_reg[index_addr] = tag_data;
        end
    end
    assign dev_data = mem_reg[index_addr];
    assign dev_drive = clear_n && !chip_sel_n
                       && write_en_n && !out_en_n;
    assign hit_pull_low = clear_n && !chip_sel_n && write_en_n && out_en_n
                          && (tag_data !== dev_data);
endmodule : ctrc_tag_ram_model
`default_nettype wire

// ---- tb/cache_tag_ram_comparator_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module cache_tag_ram_comparator_tb;
    import ctrc_pkg::*;
    logic sys_clk = 0, nrst = 0, req_valid = 0;
    ctrc_op_e req_op = CTRC_OP_LOOKUP;
    logic [20:0] req_addr = 21'h00_0000;
    logic [7:0] req_wdata = 8'h00, float_reg = 8'h3C;
    logic req_ready, rsp_valid, rsp_hit, chip_sel_n, write_en_n, out_en_n;
    logic clear_n, tag_data_oe_n, dev_drive, hit_pull_low, hit_n_in;
    logic [7:0] rsp_rdata, tag_data_out, dev_data, tag_data;
    logic [12:0] index_addr;
    int num_errors = 0, checks = 0;
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) float_reg <= ~float_reg;
    // ========================================
    // wire resolution: undriven data toggles, hit pulled up
    assign tag_data = !tag_data_oe_n ? tag_data_out
                    : dev_drive ? dev_data : float_reg;
    assign hit_n_in = !hit_pull_low;
    ctrc_host uut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
        .rsp_rdata(rsp_rdata), .index_addr(index_addr),
        .chip_sel_n(chip_sel_n),
        .write_en_n(write_en_n), .out_en_n(out_en_n), .clear_n(clear_n),
        .tag_data_in(tag_data), .tag_data_out(tag_data_out),
        .tag_data_oe_n(tag_data_oe_n), .hit_n_in(hit_n_in));
    ctrc_tag_ram_model dev (.index_addr(index_addr), .chip_sel_n(chip_sel_n),
        .write_en_n(write_en_n), .out_en_n(out_en_n), .clear_n(clear_n),
        .tag_data(tag_data), .dev_data(dev_data), .dev_drive(dev_drive),
        .hit_pull_low(hit_pull_low));
    // ========================================
    // checks and closing
    task automatic chk_hit(string what, logic e, logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask : chk_hit
    task automatic chk_data(string what, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_data
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // ========================================
    // one request, answer awaited under a bound
    task automatic do_req(ctrc_op_e op, logic [20:0] addr, logic [7:0] wd);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk_hit("req_ready", 1'b1, req_ready);
        if (req_ready !== 1'b1) close_out;
        req_valid = 1'b1;
        req_op = op;
        req_addr = addr;
        req_wdata = wd;
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (op != CTRC_OP_CLEAR && rsp_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (op != CTRC_OP_CLEAR) chk_data("latency", 8'h04, n[7:0]);
        if (op != CTRC_OP_CLEAR && rsp_valid !== 1'b1) close_out;
    endtask : do_req
    // ========================================
    // scenarios
    task automatic t_after_clear;
        do_req(CTRC_OP_READ, 21'h00_0000, 8'h00);
        chk_data("read idx0", 8'h00, rsp_rdata);
        do_req(CTRC_OP_LOOKUP, {8'h00, 13'h1FFF}, 8'h00);
        chk_hit("zero tag", 1'b1, rsp_hit);
        $display("test after_clear done");
    endtask : t_after_clear
    task automatic t_write_read;
        logic [12:0] idx [3] = '{13'h0000, 13'h1FFF, 13'h0ABC};
        logic [7:0] val [3] = '{8'h5A, 8'hC3, 8'hFF};
        for (int i = 0; i < 3; i++) begin
            do_req(CTRC_OP_WRITE, {8'hEE, idx[i]}, val[i]);
        end
        for (int i = 0; i < 3; i++) begin
            do_req(CTRC_OP_READ, {8'h00, idx[i]}, 8'h00);
            chk_data("read back", val[i], rsp_rdata);
            chk_hit("read hit", 1'b0, rsp_hit);
        end
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_compare;
        do_req(CTRC_OP_WRITE, {8'h00, 13'h0123}, 8'h96);
        do_req(CTRC_OP_LOOKUP, {8'h96, 13'h0123}, 8'h00);
        chk_hit("match", 1'b1, rsp_hit);
        for (int b = 0; b < 8; b++) begin
            do_req(CTRC_OP_LOOKUP, {8'h96 ^ (8'h01 << b), 13'h0123}, 8'h00);
            chk_hit("bit miss", 1'b0, rsp_hit);
        end
        do_req(CTRC_OP_LOOKUP, {8'h96, 13'h0124}, 8'h00);
        chk_hit("index miss", 1'b0, rsp_hit);
        $display("test compare done");
    endtask : t_compare
    task automatic t_clear_op;
        do_req(CTRC_OP_CLEAR, 21'h00_0000, 8'h00);
        do_req(CTRC_OP_READ, {8'h00, 13'h0ABC}, 8'h00);
        chk_data("cleared", 8'h00, rsp_rdata);
        do_req(CTRC_OP_LOOKUP, {8'h00, 13'h0123}, 8'h00);
        chk_hit("cleared hit", 1'b1, rsp_hit);
        $display("test clear_op done");
    endtask : t_clear_op
    task automatic t_reset_mid;
        do_req(CTRC_OP_WRITE, {8'h00, 13'h0005}, 8'h77);
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        do_req(CTRC_OP_READ, {8'h00, 13'h0005}, 8'h00);
        chk_data("reset clear", 8'h00, rsp_rdata);
        $display("test reset_mid done");
    endtask : t_reset_mid
    initial begin
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        t_after_clear;
        t_write_read;
        t_compare;
        t_clear_op;
        t_reset_mid;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("BAD run length expected end seen hang");
        close_out;
    end
endmodule : cache_tag_ram_comparator_tb
`default_nettype wire
